// ### core/pio_top.sv
// parallel port block: three bidirectional ports and one input port
// What this block does
// - three 8-bit bidirectional ports, per-line direction, one 8-bit input port.
// - direction bit one drives the pin, zero makes it an input.
// - reset clears all direction registers, pins start as inputs.
// - reset leaves the port data latches untouched.
// - data writes always load the latch; pin driven only when direction one, or on third port pin two while clock select is set.
// - data read gives pin for input lines, latch for output lines.
// - direction registers read back the value last written.
// - clock select drives CPU clock on third port pin two, forced output.
// - clock select bit 3 cleared by reset, kept through stop and wait.
// - converter on makes input pins analog, else plain digital inputs.
// - reset clears converter on, input port starts digital.
// - input port data readable any time, returning pin levels.
// - open-drain emulation by toggling direction with latch at zero.
`timescale 1ns/1ps
module pio_top
  import pio_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  // register port
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  // first port pins
  input wire logic [7:0] PORT1_PIN_I,
  output logic [7:0] PORT1_PIN_O,
  output logic [7:0] PORT1_PIN_OE_O,
  // second port pins
  input wire logic [7:0] PORT2_PIN_I,
  output logic [7:0] PORT2_PIN_O,
  output logic [7:0] PORT2_PIN_OE_O,
  // third port pins
  input wire logic [7:0] PORT3_PIN_I,
  output logic [7:0] PORT3_PIN_O,
  output logic [7:0] PORT3_PIN_OE_O,
  // input-only port, converter and clock-out control hookup
  input wire logic [7:0] INPUT_PORT_PINS_I,
  output logic CONVERTER_ON_O,
  output logic [7:0] CONV_CTL_O,
  output logic [7:0] CLKOUT_CTL_O
);
  logic [7:0] clkout_ctl_reg;
  logic [7:0] conv_ctl_reg;
  logic [7:0] in_sync1_reg;
  logic [7:0] in_sync2_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] p1_data, p2_data, p3_data;
  logic [7:0] p1_dir, p2_dir, p3_dir;
  logic [7:0] p3_pin;
  logic [7:0] p3_force;
  logic clk_sel;

  assign clk_sel = clkout_ctl_reg[PIO_CLKOUT_BIT];

  // control registers; no stop or wait input touches them
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      clkout_ctl_reg <= PIO_CTL_RESET;
    end
    else if (WR_I && ADDR_I == PIO_OFS_CLKOUT_CTL)
    begin
      clkout_ctl_reg <= WDATA_I & PIO_CLKOUT_CTL_MASK;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      conv_ctl_reg <= PIO_CTL_RESET;
    end
    else if (WR_I && ADDR_I == PIO_OFS_CONV_CTL)
    begin
      conv_ctl_reg <= WDATA_I & PIO_CONV_CTL_MASK;
    end
  end

  assign CONVERTER_ON_O = conv_ctl_reg[PIO_CONV_ON_BIT];
  assign CONV_CTL_O = conv_ctl_reg;
  assign CLKOUT_CTL_O = clkout_ctl_reg;

  // input-only port synchroniser
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      in_sync1_reg <= PIO_ZERO;
      in_sync2_reg <= PIO_ZERO;
    end
    else
    begin
      in_sync1_reg <= INPUT_PORT_PINS_I;
      in_sync2_reg <= in_sync1_reg;
    end
  end

  // three bidirectional ports
  pio_port u_port1 (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .data_we_i(WR_I && ADDR_I == PIO_OFS_PORT1_DATA),
    .dir_we_i(WR_I && ADDR_I == PIO_OFS_PORT1_DIR),
    .wdata_i(WDATA_I),
    .dir_force_i(PIO_ZERO),
    .data_rd_o(p1_data),
    .dir_rd_o(p1_dir),
    .pin_i(PORT1_PIN_I),
    .pin_o(PORT1_PIN_O),
    .pin_oe_o(PORT1_PIN_OE_O)
  );

  pio_port u_port2 (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .data_we_i(WR_I && ADDR_I == PIO_OFS_PORT2_DATA),
    .dir_we_i(WR_I && ADDR_I == PIO_OFS_PORT2_DIR),
    .wdata_i(WDATA_I),
    .dir_force_i(PIO_ZERO),
    .data_rd_o(p2_data),
    .dir_rd_o(p2_dir),
    .pin_i(PORT2_PIN_I),
    .pin_o(PORT2_PIN_O),
    .pin_oe_o(PORT2_PIN_OE_O)
  );

  always_comb
  begin
    p3_force = PIO_ZERO;
    p3_force[PIO_CLK_PIN] = clk_sel;
  end

  pio_port u_port3 (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .data_we_i(WR_I && ADDR_I == PIO_OFS_PORT3_DATA),
    .dir_we_i(WR_I && ADDR_I == PIO_OFS_PORT3_DIR),
    .wdata_i(WDATA_I),
    .dir_force_i(p3_force),
    .data_rd_o(p3_data),
    .dir_rd_o(p3_dir),
    .pin_i(PORT3_PIN_I),
    .pin_o(p3_pin),
    .pin_oe_o(PORT3_PIN_OE_O)
  );

  // pin two carries the core clock when selected
  always_comb
  begin
    PORT3_PIN_O = p3_pin;
    PORT3_PIN_O[PIO_CLK_PIN] = clk_sel ? CORE_CLK_I : p3_pin[PIO_CLK_PIN];
  end

  // read mux, unmapped reads zero
  always_comb
  begin
    rdata_next = PIO_ZERO;
    unique case (ADDR_I)
      PIO_OFS_PORT1_DATA: rdata_next = p1_data;
      PIO_OFS_PORT2_DATA: rdata_next = p2_data;
      PIO_OFS_PORT3_DATA: rdata_next = p3_data;
      PIO_OFS_INPUT_DATA: rdata_next = in_sync2_reg;
      PIO_OFS_PORT1_DIR: rdata_next = p1_dir;
      PIO_OFS_PORT2_DIR: rdata_next = p2_dir;
      PIO_OFS_PORT3_DIR: rdata_next = p3_dir;
      PIO_OFS_CLKOUT_CTL: rdata_next = clkout_ctl_reg;
      PIO_OFS_CONV_CTL: rdata_next = conv_ctl_reg;
      default: rdata_next = PIO_ZERO;
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rdata_reg <= PIO_ZERO;
    end
    else if (RD_I)
    begin
      rdata_reg <= rdata_next;
    end
    else
    begin
      rdata_reg <= PIO_ZERO;
    end
  end

  assign RDATA_O = rdata_reg;
endmodule : pio_top

// ### core/pio_pkg.sv
// constants for the parallel port block
package pio_pkg;
  localparam int PIO_AW = 4;
  localparam int PIO_DW = 8;
  localparam logic [3:0] PIO_OFS_PORT1_DATA = 4'h0;
  localparam logic [3:0] PIO_OFS_PORT2_DATA = 4'h1;
  localparam logic [3:0] PIO_OFS_PORT3_DATA = 4'h2;
  localparam logic [3:0] PIO_OFS_INPUT_DATA = 4'h3;
  localparam logic [3:0] PIO_OFS_PORT1_DIR = 4'h4;
  localparam logic [3:0] PIO_OFS_PORT2_DIR = 4'h5;
  localparam logic [3:0] PIO_OFS_PORT3_DIR = 4'h6;
  localparam logic [3:0] PIO_OFS_CLKOUT_CTL = 4'h7;
  localparam logic [3:0] PIO_OFS_CONV_CTL = 4'h9;
  localparam logic [7:0] PIO_DIR_RESET = 8'h00;
  localparam logic [7:0] PIO_CTL_RESET = 8'h00;
  localparam logic [7:0] PIO_ZERO = 8'h00;
  localparam int PIO_CLKOUT_BIT = 3;
  localparam int PIO_CONV_ON_BIT = 5;
  localparam int PIO_CLK_PIN = 2;
  localparam logic [7:0] PIO_CLKOUT_CTL_MASK = 8'h0F;
  localparam logic [7:0] PIO_CONV_CTL_MASK = 8'hEF;
endpackage : pio_pkg

// ### core/pio_port.sv
// one bidirectional 8-bit port: latch, direction and read mux
`timescale 1ns/1ps
module pio_port
  import pio_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register access
  input wire logic data_we_i,
  input wire logic dir_we_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] dir_force_i,
  output logic [7:0] data_rd_o,
  output logic [7:0] dir_rd_o,
  // pins
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe_o
);
  logic [7:0] latch_reg;
  logic [7:0] dir_reg;
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  logic [7:0] eff_dir;

  // latch has no reset
  always_ff @(posedge clk_i)
  begin
    if (data_we_i)
    begin
      latch_reg <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dir_reg <= PIO_DIR_RESET;
    end
    else if (dir_we_i)
    begin
      dir_reg <= wdata_i;
    end
  end

  // pin synchroniser
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync1_reg <= PIO_ZERO;
      sync2_reg <= PIO_ZERO;
    end
    else
    begin
      sync1_reg <= pin_i;
      sync2_reg <= sync1_reg;
    end
  end

  assign eff_dir = dir_reg | dir_force_i;
  assign pin_oe_o = eff_dir;
  assign pin_o = latch_reg;
  assign dir_rd_o = dir_reg;

  // per-bit read select
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_rd
      assign data_rd_o[g] = eff_dir[g] ? latch_reg[g] : sync2_reg[g];
    end
  endgenerate
endmodule : pio_port

// ### test/pio_board.sv
// board model driving the pins of one port
`timescale 1ns/1ps
module pio_board
(
  // design side
  input wire logic [7:0] drv_i,
  input wire logic [7:0] oe_i,
  // board side
  input wire logic [7:0] ext_i,
  output logic [7:0] pin_o
);
  // driven lines follow the design, released lines the board
  assign pin_o = (drv_i & oe_i) | (ext_i & ~oe_i);
endmodule : pio_board

// ### test/pio_top_sva.sv
// assertion checker for the parallel port block
`timescale 1ns/1ps
module pio_top_chk
  import pio_pkg::*;
(
  // watched ports
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] RDATA_O,
  input wire logic [7:0] PORT1_PIN_O,
  input wire logic [7:0] PORT1_PIN_OE_O,
  input wire logic [7:0] PORT2_PIN_OE_O,
  input wire logic [7:0] PORT3_PIN_OE_O,
  input wire logic CONVERTER_ON_O,
  input wire logic [7:0] CLKOUT_CTL_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  property p_dir; WR_I && ADDR_I == 4'h4
    |=> PORT1_PIN_OE_O == $past(WDATA_I); endproperty
  a_dir: assert property (p_dir) else $error("dir");
  property p_lat; WR_I && ADDR_I == 4'h0
    |=> PORT1_PIN_O == $past(WDATA_I); endproperty
  a_lat: assert property (p_lat) else $error("latch");
  property p_rdz; !RD_I |=> RDATA_O == 8'h00; endproperty
  a_rdz: assert property (p_rdz) else $error("rdata");
  property p_rdd; RD_I && ADDR_I == 4'h5
    |=> RDATA_O == PORT2_PIN_OE_O; endproperty
  a_rdd: assert property (p_rdd) else $error("dir read");
  property p_clk; CLKOUT_CTL_O[3] |-> PORT3_PIN_OE_O[2]; endproperty
  a_clk: assert property (p_clk) else $error("clk oe");
  property p_ctl; WR_I && ADDR_I == 4'h7
    |=> CLKOUT_CTL_O == ($past(WDATA_I) & 8'h0F); endproperty
  a_ctl: assert property (p_ctl) else $error("ctl");
  property p_conv; WR_I && ADDR_I == 4'h9
    |=> {7'h00, CONVERTER_ON_O} == (($past(WDATA_I) >> 5) & 8'h01);
  endproperty
  a_conv: assert property (p_conv) else $error("conv");
  property p_hold; !(WR_I && ADDR_I == 4'h5)
    |=> $stable(PORT2_PIN_OE_O); endproperty
  a_hold: assert property (p_hold) else $error("hold");
endmodule : pio_top_chk
bind pio_top pio_top_chk i_chk (.CORE_CLK_I(CORE_CLK_I),
  .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
  .RD_I(RD_I), .RDATA_O(RDATA_O), .PORT1_PIN_O(PORT1_PIN_O),
  .PORT1_PIN_OE_O(PORT1_PIN_OE_O), .PORT2_PIN_OE_O(PORT2_PIN_OE_O),
  .PORT3_PIN_OE_O(PORT3_PIN_OE_O), .CONVERTER_ON_O(CONVERTER_ON_O),
  .CLKOUT_CTL_O(CLKOUT_CTL_O));

// ### test/tb_pio_top.sv
// testbench for the parallel port block
`timescale 1ns/1ps
module tb_pio_top
  import pio_pkg::*;
;
  logic clk, rst_n, wr, rd, con;
  logic [3:0] addr;
  logic [7:0] wd, rdata, d, x1, x2, x3, xd, o1, o2, o3;
  logic [7:0] e1, e2, e3, i1, i2, i3, cc, kc;
  int bad_count, n_checks;
  always #2.5 clk = ~clk;
  pio_top i_dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr),
    .WDATA_I(wd), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .PORT1_PIN_I(i1), .PORT1_PIN_O(o1), .PORT1_PIN_OE_O(e1),
    .PORT2_PIN_I(i2), .PORT2_PIN_O(o2), .PORT2_PIN_OE_O(e2),
    .PORT3_PIN_I(i3), .PORT3_PIN_O(o3), .PORT3_PIN_OE_O(e3),
    .INPUT_PORT_PINS_I(xd), .CONVERTER_ON_O(con), .CONV_CTL_O(cc),
    .CLKOUT_CTL_O(kc));
  pio_board i_b1 (.drv_i(o1), .oe_i(e1), .ext_i(x1), .pin_o(i1));
  pio_board i_b2 (.drv_i(o2), .oe_i(e2), .ext_i(x2), .pin_o(i2));
  pio_board i_b3 (.drv_i(o3), .oe_i(e3), .ext_i(x3), .pin_o(i3));
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask : chk
  task wrt(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= v;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wrt
  task rdt(input logic [3:0] a, output logic [7:0] v);
    repeat (3) @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rdt
  task t_dir;
    chk(e1 | e2 | e3, PIO_DIR_RESET);
    chk(kc, PIO_CTL_RESET);
    chk({7'h00, con}, 8'h00);
    for (int a = 4; a < 7; a++)
    begin
      rdt(a[3:0], d);
      chk(d, PIO_DIR_RESET);
      wrt(a[3:0] - 4'h4, 8'h3C);
      wrt(a[3:0], 8'hA5);
      rdt(a[3:0], d);
      chk(d, 8'hA5);
    end
    chk(e1 & e2 & e3, 8'hA5);
  endtask : t_dir
  task t_mix;
    @(posedge clk);
    x1 <= 8'h0F;
    rdt(4'h0, d);
    chk(d, 8'h2E);
    wrt(4'h4, 8'h00);
    wrt(4'h0, 8'h81);
    chk(o1, 8'h81);
    rdt(4'h0, d);
    chk(d, 8'h0F);
  endtask : t_mix
  task t_od;
    @(posedge clk);
    x2 <= 8'hFF;
    wrt(4'h1, 8'h00);
    wrt(4'h5, 8'h01);
    rdt(4'h1, d);
    chk(d, 8'hFE);
    wrt(4'h5, 8'h00);
    rdt(4'h1, d);
    chk(d, 8'hFF);
    // no read-modify-write: latch keeps zero, pin drives low again
    wrt(4'h5, 8'h01);
    chk(i2, 8'hFE);
  endtask : t_od
  task t_clk;
    @(posedge clk);
    x3 <= 8'hFF;
    wrt(4'h2, 8'h00);
    wrt(4'h6, 8'h00);
    wrt(4'h7, 8'hF8);
    chk(kc, 8'h08);
    chk({7'h00, o3[PIO_CLK_PIN]}, 8'h01);
    @(negedge clk);
    #1;
    chk({7'h00, o3[PIO_CLK_PIN]}, 8'h00);
    chk(e3, 8'h04);
    rdt(4'h2, d);
    chk(d, 8'hFB);
    wrt(4'h7, 8'h00);
    chk(e3, 8'h00);
  endtask : t_clk
  task t_inp;
    @(posedge clk);
    xd <= 8'h96;
    wrt(4'h9, 8'h30);
    chk({7'h00, con}, 8'h01);
    chk(cc, 8'h20);
    wrt(4'h3, 8'h00);
    rdt(4'h3, d);
    chk(d, 8'h96);
    wrt(4'h8, 8'hFF);
    rdt(4'h8, d);
    chk(d, 8'h00);
  endtask : t_inp
  task t_rst;
    wrt(4'h0, 8'h5A);
    wrt(4'h7, 8'h08);
    wrt(4'h9, 8'h20);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(e1 | e2 | e3, PIO_DIR_RESET);
    chk(kc, PIO_CTL_RESET);
    chk({7'h00, con}, 8'h00);
    wrt(4'h4, 8'hFF);
    chk(o1, 8'h5A);
  endtask : t_rst
  task complete_run;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  initial
  begin
    #20000;
    bad_count++;
    complete_run();
  end
  initial
  begin
    {clk, rst_n, wr, rd, addr, wd} = '0;
    {x1, x2, x3, xd} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_dir();
    t_mix();
    t_od();
    t_clk();
    t_inp();
    t_rst();
    complete_run();
  end
endmodule : tb_pio_top
